// *** include/fir_pkg.sv ***
// Behaviour
// - up to 16 filters, 255 taps, upsample 6
// - one multiply-accumulate tap per clock, concurrent
// - samples and coefficients share 1024-word memory
// - coefficient high bits held, merged on low
// - coefficients written sequentially, pointer advances on low
// - sample address from 16 per-buffer pointers
// - length picks pointer versus base address bits
// - length code is log2 minus five
// - start loads coefficient read pointer, increments
// - data index loads buffer pointer minus one
// - tap counter loaded, engine runs until zero
// - 34-bit accumulator shift register, length one default
// - first product loaded, feedback forced zero
// - processor writes several samples per start
// - phase counter wraps at upsample value until done
// - upsample sets accumulator length and load window
// - result ports map onto accumulator stages
// - idle flag bit 0 reads one when idle
// - overflow flag bit 15 for accumulator stage 0
package fir_pkg;
    localparam logic [7:0] ADDR_SAMPLE = 8'h28;
    localparam logic [7:0] ADDR_COEF_LOW = 8'h29;
    localparam logic [7:0] ADDR_COEF_HIGH = 8'h2A;
    localparam logic [7:0] ADDR_SETUP = 8'h2B;
    localparam logic [7:0] ADDR_BUFCFG = 8'h2C;
    localparam logic [7:0] ADDR_START = 8'h2D;
    localparam logic [7:0] ADDR_COEF_CLEAR = 8'h2E;
    localparam logic [7:0] ADDR_FLAGS = 8'h2F;
    localparam int MEM_WORDS = 1024;
    localparam int ACC_W = 34;
    localparam int ACC_STAGES = 7;
    localparam int FLAG_IDLE_BIT = 0;
    localparam int FLAG_OVF_BIT = 15;
    localparam int TAPS_LSB = 0;
    localparam int INTRP_LSB = 8;
    localparam int BASE_LSB = 0;
    localparam int LEN_LSB = 4;
    localparam int RESULT_LSB = 17;
    localparam logic [9:0] COEF_PTR_RESET = 10'h000;
    localparam logic [7:0] TAPS_RESET = 8'h1F;
    localparam logic [2:0] INTRP_RESET = 3'h0;
    localparam logic [1:0] LEN_RESET = 2'h0;
    localparam logic [3:0] BASE_RESET = 4'h0;
    typedef enum logic [1:0] {FIR_IDLE, FIR_RUN, FIR_DRAIN} fir_state_t;
endpackage

// *** include/fir_if.sv ***
`timescale 1ns/10ps
interface fir_if;
    logic [7:0] portAddr;
    logic [15:0] portWrData;
    logic portWr;
    logic portRd;
    logic [15:0] portRdData;
    modport dev (input portAddr, portWrData, portWr, portRd, output portRdData);
    modport cpu (output portAddr, portWrData, portWr, portRd, input portRdData);
endinterface

// *** rtl/fir_coproc.sv ***
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
module fir_coproc
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // processor port
    fir_if.dev bus
);
    logic [17:0] mem [0:fir_pkg::MEM_WORDS-1];
    logic [7:0] dataPtr [0:15];
    logic [1:0] coefHigh_reg;
    logic [9:0] coefWrPtr_reg;
    logic [7:0] taps_reg;
    logic [2:0] intrp_reg;
    logic [1:0] lenCode_reg;
    logic [3:0] base_reg;
    fir_pkg::fir_state_t state_reg;
    logic [9:0] coefRdPtr_reg;
    logic [7:0] dataIdx_reg;
    logic [7:0] tapCnt_reg;
    logic [2:0] phase_reg;
    logic [7:0] loadWin_reg;
    logic [17:0] coefQ_reg;
    logic [15:0] sampleQ_reg;
    logic valid_reg;
    logic first_reg;
    logic [fir_pkg::ACC_W-1:0] acc_reg [0:fir_pkg::ACC_STAGES-1];
    logic [fir_pkg::ACC_STAGES-1:0] ovf_reg;
    logic [15:0] rdData_reg;
    logic wrEv;
    logic [9:0] dataAddr;
    logic [9:0] rdAddr;
    logic [7:0] curPtr;
    logic tapsDone;
    logic [fir_pkg::ACC_W-1:0] product;
    logic [fir_pkg::ACC_W-1:0] feedback;
    logic [fir_pkg::ACC_W-1:0] sum;
    logic sumOvf;
    logic [2:0] accLast;
    assign wrEv = bus.portWr;
    assign curPtr = dataPtr[base_reg];
    assign tapsDone = (tapCnt_reg == 8'h00);
    assign accLast = intrp_reg;
    // merge pointer and base bits by length code
    function automatic logic [9:0] bufAddr(input logic [3:0] b, input logic [1:0] l, input logic [7:0] p);
        logic [9:0] a;
        unique case (l)
            2'h0: a = {b[3:0], 1'b0, p[4:0]} & 10'h3FF;
            2'h1: a = {b[3:1], 1'b0, p[5:0]};
            2'h2: a = {b[3:2], 1'b0, p[6:0]};
            2'h3: a = {b[3], 1'b0, p[7:0]};
        endcase
        return a;
    endfunction
    assign dataAddr = bufAddr(base_reg, lenCode_reg, curPtr);
    assign rdAddr = bufAddr(base_reg, lenCode_reg, dataIdx_reg);
    // configuration writes
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            coefHigh_reg <= 2'h0;
            taps_reg <= fir_pkg::TAPS_RESET;
            intrp_reg <= fir_pkg::INTRP_RESET;
            lenCode_reg <= fir_pkg::LEN_RESET;
            base_reg <= fir_pkg::BASE_RESET;
        end
        else if (wrEv)
        begin
            if (bus.portAddr == fir_pkg::ADDR_COEF_HIGH)
                coefHigh_reg <= bus.portWrData[1:0];
            if (bus.portAddr == fir_pkg::ADDR_SETUP)
            begin
                taps_reg <= bus.portWrData[fir_pkg::TAPS_LSB +: 8];
                intrp_reg <= bus.portWrData[fir_pkg::INTRP_LSB +: 3];
            end
            if (bus.portAddr == fir_pkg::ADDR_BUFCFG)
            begin
                base_reg <= bus.portWrData[fir_pkg::BASE_LSB +: 4];
                lenCode_reg <= bus.portWrData[fir_pkg::LEN_LSB +: 2];
            end
        end
    end
    // coefficient write pointer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            coefWrPtr_reg <= fir_pkg::COEF_PTR_RESET;
        else if (wrEv && bus.portAddr == fir_pkg::ADDR_COEF_CLEAR)
            coefWrPtr_reg <= fir_pkg::COEF_PTR_RESET;
        else if (wrEv && bus.portAddr == fir_pkg::ADDR_COEF_LOW)
            coefWrPtr_reg <= coefWrPtr_reg + 10'h001;
    end
    // shared memory: write side and engine read side
    always_ff @(posedge core_clk)
    begin
        if (wrEv && bus.portAddr == fir_pkg::ADDR_COEF_LOW)
            mem[coefWrPtr_reg] <= {coefHigh_reg, bus.portWrData};
        else if (wrEv && bus.portAddr == fir_pkg::ADDR_SAMPLE)
            mem[dataAddr] <= {2'h0, bus.portWrData};
        coefQ_reg <= mem[coefRdPtr_reg];
        sampleQ_reg <= mem[rdAddr][15:0];
    end
    // per-buffer sample pointers, cleared so no buffer starts unknown
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 16; i++)
                dataPtr[i] <= 8'h00;
        end
        else if (wrEv && bus.portAddr == fir_pkg::ADDR_SAMPLE)
            dataPtr[base_reg] <= curPtr + 8'h01;
    end
    // engine sequencing
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state_reg <= fir_pkg::FIR_IDLE;
            coefRdPtr_reg <= 10'h000;
            dataIdx_reg <= 8'h00;
            tapCnt_reg <= 8'h00;
            phase_reg <= 3'h0;
            valid_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                fir_pkg::FIR_IDLE:
                begin
                    valid_reg <= 1'b0;
                    if (wrEv && bus.portAddr == fir_pkg::ADDR_START)
                    begin
                        coefRdPtr_reg <= bus.portWrData[9:0];
                        dataIdx_reg <= curPtr - 8'h01;
                        tapCnt_reg <= taps_reg;
                        phase_reg <= 3'h0;
                        state_reg <= fir_pkg::FIR_RUN;
                    end
                end
                fir_pkg::FIR_RUN:
                begin
                    valid_reg <= 1'b1;
                    coefRdPtr_reg <= coefRdPtr_reg + 10'h001;
                    tapCnt_reg <= tapCnt_reg - 8'h01;
                    if (intrp_reg == 3'h0 || phase_reg == intrp_reg)
                    begin
                        phase_reg <= 3'h0;
                        dataIdx_reg <= dataIdx_reg - 8'h01;
                    end
                    else
                        phase_reg <= phase_reg + 3'h1;
                    if (tapCnt_reg == 8'h01 || tapsDone)
                        state_reg <= fir_pkg::FIR_DRAIN;
                end
                fir_pkg::FIR_DRAIN:
                begin
                    valid_reg <= 1'b0;
                    phase_reg <= 3'h0;
                    if (!valid_reg)
                        state_reg <= fir_pkg::FIR_IDLE;
                end
            endcase
        end
    end
    // load window delay line, one bit per interpolation phase
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            loadWin_reg <= 8'h00;
        else if (state_reg == fir_pkg::FIR_IDLE && wrEv && bus.portAddr == fir_pkg::ADDR_START)
            loadWin_reg <= 8'hFF >> (3'h7 - intrp_reg);
        else if (state_reg == fir_pkg::FIR_RUN)
            loadWin_reg <= {1'b0, loadWin_reg[7:1]}; // one fetch per bit, so first product of each phase marked once
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            first_reg <= 1'b0;
        else
            first_reg <= loadWin_reg[0] && state_reg == fir_pkg::FIR_RUN;
    end
    // multiply and add
    assign product = ACC_EXT($signed(sampleQ_reg) * $signed(coefQ_reg));
    function automatic logic [fir_pkg::ACC_W-1:0] ACC_EXT(input logic signed [33:0] v);
        return v;
    endfunction
    assign feedback = first_reg ? '0 : acc_reg[accLast];
    assign sum = feedback + product;
    assign sumOvf = (feedback[33] == product[33]) && (sum[33] != feedback[33]);
    // accumulator shift register
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < fir_pkg::ACC_STAGES; i++)
                acc_reg[i] <= '0;
            ovf_reg <= '0;
        end
        else if (valid_reg)
        begin
            acc_reg[0] <= sum;
            ovf_reg[0] <= first_reg ? sumOvf : (ovf_reg[accLast] | sumOvf);
            for (int i = 1; i < fir_pkg::ACC_STAGES; i++)
            begin
                acc_reg[i] <= acc_reg[i-1];
                ovf_reg[i] <= ovf_reg[i-1];
            end
        end
    end
    // read port, data one cycle after strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            rdData_reg <= 16'h0000;
        else if (bus.portRd)
        begin
            rdData_reg <= 16'h0000;
            if (bus.portAddr == fir_pkg::ADDR_FLAGS)
            begin
                rdData_reg[fir_pkg::FLAG_IDLE_BIT] <= (state_reg == fir_pkg::FIR_IDLE);
                rdData_reg[fir_pkg::FLAG_OVF_BIT] <= ovf_reg[0];
            end
            else if (bus.portAddr >= fir_pkg::ADDR_SAMPLE && bus.portAddr < fir_pkg::ADDR_FLAGS)
                rdData_reg <= acc_reg[3'(bus.portAddr - fir_pkg::ADDR_SAMPLE)][fir_pkg::RESULT_LSB +: 16];
        end
    end
    assign bus.portRdData = rdData_reg;
endmodule

// *** rtl/fir_cpu_port.sv ***
`timescale 1ns/10ps
module fir_cpu_port
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // user request side
    input wire logic reqWr,
    input wire logic reqRd,
    input wire logic [7:0] reqAddr,
    input wire logic [15:0] reqData,
    output logic [15:0] ansData,
    output logic ansValid,
    // link to coprocessor
    fir_if.cpu bus
);
    logic [7:0] addr_reg;
    logic [15:0] wd_reg;
    logic wr_reg;
    logic rd_reg;
    logic rdPend_reg;
    logic [15:0] ans_reg;
    logic ansV_reg;
    // register requests onto the port; coefficient order kept by user
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            addr_reg <= 8'h00;
            wd_reg <= 16'h0000;
            wr_reg <= 1'b0;
            rd_reg <= 1'b0;
        end
        else
        begin
            addr_reg <= reqAddr;
            wd_reg <= reqData;
            wr_reg <= reqWr;
            rd_reg <= reqRd && !reqWr;
        end
    end
    // capture answer one cycle after read strobe
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdPend_reg <= 1'b0;
            ans_reg <= 16'h0000;
            ansV_reg <= 1'b0;
        end
        else
        begin
            rdPend_reg <= rd_reg;
            ansV_reg <= rdPend_reg;
            if (rdPend_reg)
                ans_reg <= bus.portRdData;
        end
    end
    assign bus.portAddr = addr_reg;
    assign bus.portWrData = wd_reg;
    assign bus.portWr = wr_reg;
    assign bus.portRd = rd_reg;
    assign ansData = ans_reg;
    assign ansValid = ansV_reg;
endmodule

// *** dv/fir_monitor.sv ***
`timescale 1ns/10ps
module fir_monitor
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // coprocessor port
    input wire logic [7:0] portAddr,
    input wire logic [15:0] portWrData,
    input wire logic portWr,
    input wire logic portRd,
    input wire logic [15:0] portRdData
);
    logic flagRd;
    logic flagRdDly;
    logic lastIdle;
    logic [7:0] tapsReg;
    logic [11:0] runCnt;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    assign flagRd = portRd && portAddr == fir_pkg::ADDR_FLAGS;
    // idle as last read, cycles since a start taken while idle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            flagRdDly <= 1'b0;
            lastIdle <= 1'b1;
            runCnt <= 12'hFFF;
        end
        else
        begin
            flagRdDly <= flagRd;
            if (flagRdDly)
                lastIdle <= portRdData[fir_pkg::FLAG_IDLE_BIT];
            if (portWr && portAddr == fir_pkg::ADDR_START && lastIdle)
                runCnt <= 12'h000;
            else if (runCnt != 12'hFFF)
                runCnt <= runCnt + 12'h001;
        end
    end
    // tap count as last written
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            tapsReg <= fir_pkg::TAPS_RESET;
        else if (portWr && portAddr == fir_pkg::ADDR_SETUP)
            tapsReg <= portWrData[7:0];
    end
    chk_flag_zero_bits: assert property (flagRd |=> portRdData[14:1] == 14'h0000)
        else $error("flag port unused bits set");
    chk_busy_after_start: assert property ((portWr && portAddr == fir_pkg::ADDR_START) ##[1:2] flagRd
        |=> !portRdData[fir_pkg::FLAG_IDLE_BIT]) else $error("idle shown right after start");
    chk_idle_not_early: assert property ((flagRd && runCnt + 12'h004 < {4'h0, tapsReg})
        |=> !portRdData[fir_pkg::FLAG_IDLE_BIT]) else $error("idle before all taps ran");
    chk_idle_in_time: assert property ((flagRd && runCnt > {4'h0, tapsReg} + 12'h010)
        |=> portRdData[fir_pkg::FLAG_IDLE_BIT]) else $error("engine still busy after tap count");
    chk_unmapped_zero: assert property ((portRd && (portAddr < 8'h28 || portAddr > 8'h2F))
        |=> portRdData == 16'h0000) else $error("unmapped read not zero");
    chk_rd_data_hold: assert property (!portRd |=> $stable(portRdData))
        else $error("read data changed without read");
    chk_strobe_excl: assert property (!(portWr && portRd))
        else $error("write and read strobe together");
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic core_clk, rst_n, reqWr, reqRd, ansValid, poll, hit;
    logic [7:0] reqAddr;
    logic [15:0] reqData, ansData, e;
    logic [15:0] expQ[$];
    int n_mismatch, check_count, w, j, k;
    int c[33];
    int s[32];
    fir_if busIf();
    // the two ends joined
    fir_coproc u_fir_coproc (.core_clk(core_clk), .rst_n(rst_n), .bus(busIf));
    fir_cpu_port u_fir_cpu_port (.core_clk(core_clk), .rst_n(rst_n), .reqWr(reqWr), .reqRd(reqRd),
        .reqAddr(reqAddr), .reqData(reqData), .ansData(ansData), .ansValid(ansValid), .bus(busIf));
    fir_monitor u_fir_monitor (.core_clk(core_clk), .rst_n(rst_n), .portAddr(busIf.portAddr),
        .portWrData(busIf.portWrData), .portWr(busIf.portWr), .portRd(busIf.portRd), .portRdData(busIf.portRdData));
    // clock
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic test_done();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reqWr <= 1'b1;
        reqAddr <= a;
        reqData <= d;
        @(posedge core_clk);
        reqWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] x, input bit p);
        @(posedge core_clk);
        reqRd <= 1'b1;
        reqAddr <= a;
        if (!p)
            expQ.push_back(x);
        @(posedge core_clk);
        reqRd <= 1'b0;
    endtask
    // stage n sums every (up+1)th tap ending at tap 30-n, result bits 32:17
    function automatic logic [15:0] expect_res(input int up, input int n);
        longint acc;
        logic [33:0] a;
        acc = 0;
        for (int i = (30 - n) % (up + 1); i < 31; i += up + 1)
            acc += longint'(c[i]) * s[(w - 1 - i / (up + 1)) & 31];
        a = acc[33:0];
        return a[32:17];
    endfunction
    // fresh coefficient set, two trailing zeros
    task automatic load();
        wr(8'h2E, 16'h0000);
        for (int i = 0; i < 33; i++)
        begin
            c[i] = (i < 31) ? int'($urandom_range(16383)) - 8192 : 0;
            wr(8'h2A, {14'h0000, c[i][17:16]});
            wr(8'h29, c[i][15:0]);
        end
    endtask
    // samples, start, second start while busy, wait idle, read
    task automatic run(input int n, input int up);
        for (int i = 0; i < n; i++)
        begin
            s[w] = int'($urandom_range(65535)) - 32768;
            wr(8'h28, s[w][15:0]);
            w = (w + 1) & 31;
        end
        wr(8'h2D, 16'h0000);
        wr(8'h2D, 16'h0005);
        rd(8'h2F, 16'h0000, 0);
        repeat (6) @(negedge core_clk);
        poll = 1'b1;
        hit = 1'b0;
        for (j = 0; j < 200 && !hit; j++)
        begin
            rd(8'h2F, 16'h0000, 1);
            for (k = 0; k < 8 && !hit; k++)
            begin
                @(negedge core_clk);
                hit = (ansValid === 1'b1) && (ansData[0] === 1'b1);
            end
        end
        @(negedge core_clk);
        poll = 1'b0;
        if (!hit)
        begin
            n_mismatch++;
            test_done();
        end
        rd(8'h28, expect_res(up, 0), 0);
        if (up > 0)
            rd(8'h29, expect_res(up, 1), 0);
        rd(8'h2F, 16'h0001, 0);
    endtask
    // compare each answer outside polling with the oldest note
    always @(posedge core_clk)
    begin
        if (ansValid === 1'b1 && !poll)
        begin
            check_count++;
            e = (expQ.size() > 0) ? expQ.pop_front() : ~ansData;
            if (ansData !== e || $isunknown(ansData))
            begin
                n_mismatch++;
                $display("Error at %0t: got %h expected %h", $time, ansData, e);
            end
        end
    end
    // main sequence
    initial
    begin
        rst_n <= 1'b0;
        reqWr <= 1'b0;
        reqRd <= 1'b0;
        reqAddr <= 8'h00;
        reqData <= 16'h0000;
        poll = 1'b0;
        w = 0;
        void'($urandom(39));
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        wr(8'h2B, 16'h001F);
        wr(8'h2C, 16'h0002);
        load();
        run(32, 0);
        load();
        run(3, 0);
        wr(8'h2B, 16'h011F);
        run(2, 1);
        rd(8'h30, 16'h0000, 0);
        repeat (10) @(posedge core_clk);
        if (expQ.size() != 0)
            n_mismatch++;
        test_done();
    end
endmodule
